// ---- psi_pkg.sv ----
// shared constants of the sample interface, plus its two-flop pin synchroniser
// assumes a single core clock; every pin input arrives asynchronously
`timescale 1ns/1ns

package psi_pkg;
  // ==========================================================================
  // widths
  localparam int CODE_W = 12;
  localparam int AIN_W  = 14;
  localparam int DIFF_W = AIN_W + 1;
  localparam int WIDE_W = DIFF_W + 2;
  localparam int IDLE_W = 20;
  localparam int CONV_W = 5;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CONV_TIME_NS   = 150;
  localparam int REFRESH_IDLE_NS = 1000000;
  localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLES = REFRESH_IDLE_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // codes and reset values
  localparam logic [CODE_W-1:0] CODE_POS_FULL = 12'h7FF;
  localparam logic [CODE_W-1:0] CODE_NEG_FULL = 12'h800;
  localparam logic [CODE_W-1:0] CODE_RESET    = 12'h000;
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_VREF = 2'h1;
  localparam logic [1:0] STRAP_VDD  = 2'h2;
endpackage : psi_pkg

module psi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : psi_sync

// ---- psi_adc_core.sv ----
// digital side of the 12-bit pipelined sampling converter
// assumes conv_clk, the analog input words and the straps come from pins
//
// How it works
// - every rising conversion clock edge starts a new conversion
// - both analog inputs sampled together; their difference enters the pipeline
// - result shows conversion time after second later start; captured at third edge
// - result is a 12-bit two's complement code on one parallel bus
// - range flag high exactly for largest positive or most negative code
// - gain pin high means gain one, low means gain two
// - reference strap picks 4.096V, 2.048V or external reference drive
// - after 1ms without clock edge an internal timer refreshes dynamic logic
`timescale 1ns/1ns

module psi_adc_core
  import psi_pkg::*;
#(
  parameter int REFRESH_CNT = REFRESH_CYCLES
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     conv_clk,
  input  wire logic signed [AIN_W-1:0]  positive_analog_input,
  input  wire logic signed [AIN_W-1:0]  negative_analog_input,
  input  wire logic                     gain_select,
  input  wire logic [1:0]               ref_strap,
  output logic [CODE_W-1:0]             sample_code_bus,
  output logic                          out_of_range_flag,
  output logic                          ref_internal_en,
  output logic                          ref_half_select,
  output logic                          dynamic_refresh
);

  // ==========================================================================
  // types and helpers
  typedef struct packed {
    logic              clk_d;
    logic [CODE_W-1:0] stage0;
    logic [CODE_W-1:0] stage1;
    logic [CODE_W-1:0] pending;
    logic              conv_busy;
    logic [CONV_W-1:0] conv_cnt;
    logic [CODE_W-1:0] code;
    logic              oor;
    logic              ref_int;
    logic              ref_half;
    logic [IDLE_W-1:0] idle_cnt;
    logic              refresh;
  } psi_state_s;

  function automatic logic [CODE_W-1:0] psi_saturate(input logic signed [WIDE_W-1:0] v);
    if (v > $signed({{(WIDE_W-CODE_W){1'b0}}, CODE_POS_FULL}))
      return CODE_POS_FULL;
    else if (v < $signed({{(WIDE_W-CODE_W){1'b1}}, CODE_NEG_FULL}))
      return CODE_NEG_FULL;
    else
      return v[CODE_W-1:0];
  endfunction : psi_saturate

  function automatic logic psi_ref_half(input logic [1:0] strap);
    return strap == STRAP_VREF;
  endfunction : psi_ref_half

  function automatic logic psi_range_edge(input logic [CODE_W-1:0] c);
    return (c == CODE_POS_FULL) || (c == CODE_NEG_FULL);
  endfunction : psi_range_edge

  localparam logic [CONV_W-1:0] CONV_LOAD    = CONV_W'(CONV_CYCLES);
  localparam logic [IDLE_W-1:0] REFRESH_LAST = IDLE_W'(REFRESH_CNT - 1);

  // ==========================================================================
  // pin synchronisation
  localparam int PIN_W = 2 * AIN_W + 4;
  logic [PIN_W-1:0] pins_s;

  psi_sync #(
    .WIDTH    (PIN_W)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({conv_clk, gain_select, ref_strap, positive_analog_input, negative_analog_input}),
    .sync_out (pins_s)
  );

  logic                     clk_s;
  logic                     gain_s;
  logic [1:0]               strap_s;
  logic signed [AIN_W-1:0]  pos_s;
  logic signed [AIN_W-1:0]  neg_s;
  assign {clk_s, gain_s, strap_s, pos_s, neg_s} = pins_s;

  // ==========================================================================
  // sampling
  psi_state_s                st;
  psi_state_s                next_st;
  logic                      start;
  logic signed [DIFF_W-1:0]  diff;
  logic signed [WIDE_W-1:0]  scaled;
  logic [CODE_W-1:0]         sample_code;

  assign start = clk_s & ~st.clk_d;

  assign diff = DIFF_W'(pos_s) - DIFF_W'(neg_s);

  // low gain pin doubles the code; half reference doubles it again
  always_comb begin
    scaled = WIDE_W'(diff);
    if (!gain_s)
      scaled = scaled <<< 1;
    if (psi_ref_half(strap_s))
      scaled = scaled <<< 1;
  end

  // two's complement code, clipped at full scale
  assign sample_code = psi_saturate(scaled);

  // ==========================================================================
  // pipeline, conversion timer, refresh timer
  always_comb begin
    next_st         = st;
    next_st.clk_d   = clk_s;
    next_st.refresh = 1'b0;
    // reference source from strap
    // strap codes 2 and 3 both mean supply: external reference drive
    next_st.ref_int  = (strap_s == STRAP_GND) || (strap_s == STRAP_VREF);
    next_st.ref_half = psi_ref_half(strap_s);

    if (st.conv_busy) begin
      if (st.conv_cnt == CONV_W'(1)) begin
        next_st.conv_busy = 1'b0;
        next_st.code      = st.pending;
      end else begin
        next_st.conv_cnt = st.conv_cnt - CONV_W'(1);
      end
    end

    if (start) begin
      // a start inside a running conversion flushes it first
      if (st.conv_busy)
        next_st.code = st.pending;
      next_st.stage0    = sample_code;
      next_st.stage1    = st.stage0;
      // second later start launches the output update
      next_st.pending   = st.stage1;
      next_st.conv_busy = 1'b1;
      next_st.conv_cnt  = CONV_LOAD;
      next_st.idle_cnt  = '0;
    end else if (st.idle_cnt == REFRESH_LAST) begin
      next_st.refresh  = 1'b1;
      next_st.idle_cnt = '0;
    end else begin
      next_st.idle_cnt = st.idle_cnt + IDLE_W'(1);
    end

    // range flag tracks the presented code
    next_st.oor = psi_range_edge(next_st.code);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{clk_d: 1'b0, stage0: CODE_RESET, stage1: CODE_RESET, pending: CODE_RESET,
              conv_busy: 1'b0, conv_cnt: '0, code: CODE_RESET, oor: 1'b0,
              ref_int: 1'b1, ref_half: 1'b0, idle_cnt: '0, refresh: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign sample_code_bus   = st.code;
  assign out_of_range_flag = st.oor;
  assign ref_internal_en   = st.ref_int;
  assign ref_half_select   = st.ref_half;
  assign dynamic_refresh   = st.refresh;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // code updates count edges after the timer load edge; the check samples it one edge later
  localparam int CONV_DLY = CONV_CYCLES + 1;

  a_edge_samples: assert property (start |=> st.stage0 == $past(sample_code))
    else $error("edge did not load a new sample");

  a_diff_taken: assert property ((start && gain_s && strap_s == STRAP_GND && diff < 15'sh07FF && diff > -15'sh0800)
                                 |=> st.stage0 == CODE_W'($past(pos_s) - $past(neg_s)))
    else $error("differential value not captured");

  a_result_delay: assert property (start |=> (st.pending == $past(st.stage1)) ##0
                                   ((st.code == $past(st.code) && !start) [*1]) or start)
    else $error("result update timing wrong");

  a_code_clip: assert property ((start && scaled > 17'sd2047) |=> st.stage0 == CODE_POS_FULL)
    else $error("positive overrange not clipped");

  a_range_flag: assert property (out_of_range_flag == (sample_code_bus == CODE_POS_FULL || sample_code_bus == CODE_NEG_FULL))
    else $error("range flag disagrees with code");

  a_gain_two: assert property ((start && !gain_s && strap_s == STRAP_GND && diff == 15'sh0258) |=> st.stage0 == 12'h4B0)
    else $error("gain two not applied");

  a_ref_strap: assert property ((strap_s != STRAP_GND && strap_s != STRAP_VREF) |=> !ref_internal_en && !ref_half_select)
    else $error("external reference strap ignored");

  a_idle_refresh: assert property ((!start && st.idle_cnt == REFRESH_LAST) |=> dynamic_refresh && st.idle_cnt == '0)
    else $error("idle refresh missing");

  a_conv_finish: assert property ((start && !st.conv_busy) |-> ##CONV_DLY (st.code == $past(st.pending) || start || $past(start)))
    else $error("conversion time not honoured");

endmodule : psi_adc_core

// ---- psi_capture_model.sv ----
// capture-side model: makes the conversion clock and latches each word
// assumes a free-running core_clk; conv_clk stands low while run is low
`timescale 1ns/1ns

module psi_capture_model
  import psi_pkg::*;
#(
  parameter int HALF = 20
) (
  input  wire logic              core_clk,
  input  wire logic              run,
  input  wire logic [CODE_W-1:0] sample_code_bus,
  input  wire logic              out_of_range_flag,
  output logic                   conv_clk,
  output logic [CODE_W-1:0]      captured,
  output logic [CODE_W-1:0]      captured_ob,
  output logic                   captured_of
);
  int cnt;
  // ==========================================================================
  // clock generation
  // rate within limits
  always @(negedge core_clk) begin
    if (run !== 1'b1) begin
      conv_clk <= 1'b0;
      cnt      <= 0;
    end else if (cnt == HALF - 1) begin
      conv_clk <= ~conv_clk;
      cnt      <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // ==========================================================================
  // capture
  // latch every rise
  always @(posedge conv_clk) begin
    captured    <= sample_code_bus;
    captured_ob <= {~sample_code_bus[CODE_W-1], sample_code_bus[CODE_W-2:0]};
    captured_of <= out_of_range_flag;
  end
endmodule : psi_capture_model

// ---- psi_tb.sv ----
// bench for the sample interface: drives pins, checks captured words and refresh
// assumes the capture model makes conv_clk and latches each word
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module tb;
  import psi_pkg::*;
  localparam int RCNT = 50;
  localparam int NROW = 16;
  localparam int TP [NROW] = '{100, 1000, 2047, 0, 2046, -2047, 5000, 600, -1024, 1023, 600, 300, 0, 0, 0, 0};
  localparam int TN [NROW] = '{0, 1500, 0, 2048, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam bit TG [NROW] = '{1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 1, 0, 1, 1, 1, 1};
  localparam int TS [NROW] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 2, 0, 0, 0};
  logic                    core_clk;
  logic                    rst_b;
  logic                    run;
  logic                    conv_clk;
  logic                    gain_select;
  logic [1:0]              ref_strap;
  logic signed [AIN_W-1:0] pos_in;
  logic signed [AIN_W-1:0] neg_in;
  logic [CODE_W-1:0]       sample_code_bus;
  logic [CODE_W-1:0]       captured;
  logic [CODE_W-1:0]       captured_ob;
  logic                    captured_of;
  logic                    out_of_range_flag;
  logic                    ref_internal_en;
  logic                    ref_half_select;
  logic                    dynamic_refresh;
  logic [CODE_W-1:0]       expq [$];
  int                      errors = 0;
  int                      comparisons = 0;
  int                      cycles = 0;
  int                      pulses = 0;
  int                      n;

  psi_adc_core #(.REFRESH_CNT(RCNT)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .conv_clk(conv_clk),
    .positive_analog_input(pos_in), .negative_analog_input(neg_in),
    .gain_select(gain_select), .ref_strap(ref_strap),
    .sample_code_bus(sample_code_bus), .out_of_range_flag(out_of_range_flag),
    .ref_internal_en(ref_internal_en), .ref_half_select(ref_half_select),
    .dynamic_refresh(dynamic_refresh));

  psi_capture_model #(.HALF(20)) capture (
    .core_clk(core_clk), .run(run), .sample_code_bus(sample_code_bus),
    .out_of_range_flag(out_of_range_flag), .conv_clk(conv_clk),
    .captured(captured), .captured_ob(captured_ob), .captured_of(captured_of));

  // ==========================================================================
  // clock, timeout and refresh monitor
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (dynamic_refresh === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  // ==========================================================================
  // helpers
  function automatic logic [CODE_W-1:0] exp_code(input logic signed [AIN_W-1:0] p, q);
    logic signed [AIN_W+3:0] d;
    d = p - q;
    if (gain_select === 1'b0) d = d * 2;
    if (ref_strap === STRAP_VREF) d = d * 2;
    if (d > 2047) d = 2047;
    else if (d < -2048) d = -2048;
    return d[CODE_W-1:0];
  endfunction : exp_code

  // inputs change one core cycle after the fall; the word three rises back is checked
  task automatic sample(input int p, input int q, input logic g, input logic [1:0] s);
    logic [CODE_W-1:0] e;
    @(negedge conv_clk);
    @(negedge core_clk);
    gain_select = g;
    ref_strap   = s;
    pos_in      = AIN_W'(p);
    neg_in      = AIN_W'(q);
    expq.push_back(exp_code(pos_in, neg_in));
    @(posedge conv_clk);
    @(negedge core_clk);
    if (expq.size() > 3) begin
      e = expq.pop_front();
      `CHK("code", e, captured)
      `CHK("flag", e == CODE_POS_FULL || e == CODE_NEG_FULL, captured_of)
      `CHK("offset", e + 12'h800, captured_ob)
    end
  endtask : sample

  task automatic wait_pulse(output int k);
    k = 0;
    while (dynamic_refresh !== 1'b1 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
  endtask : wait_pulse

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // tests
  initial begin
    rst_b       = 1'b0;
    run         = 1'b0;
    gain_select = 1'b1;
    ref_strap   = STRAP_GND;
    pos_in      = '0;
    neg_in      = '0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    run   = 1'b1;
    for (int i = 0; i < NROW; i++) sample(TP[i], TN[i], TG[i], 2'(TS[i]));
    $display("test stream done");
    `CHK("idle_pulses", 0, pulses)
    run = 1'b0;
    wait_pulse(n);
    // last rise needs two sync edges before the idle count restarts
    `CHK("first_gap", RCNT + 2, n)
    `CHK("pulse_seen", 1'b1, dynamic_refresh)
    @(negedge core_clk);
    `CHK("pulse_width", 1'b0, dynamic_refresh)
    wait_pulse(n);
    `CHK("refresh_gap", RCNT - 1, n)
    $display("test refresh done");
    for (int s = 0; s < 4; s++) begin
      ref_strap = 2'(s);
      repeat (4) @(negedge core_clk);
      `CHK("ref_en", s < 2, ref_internal_en)
      `CHK("ref_half", s == 1, ref_half_select)
    end
    $display("test reference done");
    ref_strap = STRAP_GND;
    expq.delete();
    run = 1'b1;
    repeat (4) sample(1234, 34, 1'b1, STRAP_GND);
    $display("test resume done");
    report_and_stop();
  end
endmodule : tb
